/* lcd_bias_voltage_control.sv */
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
`include "lcd_bias_consts.svh"

// Summary of operation
// R1 - Five-bit contrast; attenuation is 31 minus code
// R2 - Three-bit divider; code 111 means external
// R3 - Byte 27H selects external divider mode
// R4 - Contrast bytes 80H..9FH, level in low bits
// R5 - Host enables regulator and follower first
// R6 - Bias command picks one-sixth or one-eighth
// R7 - Host powers off via display-off, all-on, power-clear
// R8 - Display-off plus all-points-on enters power save
// R9 - Hardware or software reset turns supply off
// R10 - Discharge path active while init pin low
// R11 - Power bits: 2 booster, 1 regulator, 0 follower
// R12 - Init: contrast 10000, divider and power zero
// R13 - Settings update immediately after command write
module lcd_bias_voltage_control (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic chip_init_pin_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output lcd_bias_pkg::drive_s drive,
    output logic booster_on,
    output logic regulator_on,
    output logic follower_on,
    output logic power_save,
    output logic display_on,
    output logic all_points_on,
    output logic discharge_en
);

    // All block state
    typedef struct packed {
        logic [4:0] vol;
        logic [2:0] div;
        logic [2:0] pwr;
        lcd_bias_pkg::bias_e bias;
        logic disp_on;
        logic allpts;
        lcd_bias_pkg::ps_e ps;
        logic [7:0] rdata;
    } state_s;

    state_s state; // Registered state
    state_s next_state; // Next value
    lcd_bias_pkg::cmd_s cmd; // Decoded command
    logic init_active; // Init pin low or soft-reset command this cycle

    // Attenuation factor from contrast code
    function automatic logic [4:0] atten_of(input logic [4:0] code);
        atten_of = `VOL_MAX - code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command decode, only writes to the command offset count
    lcd_cmd_decode u_dec (
        .byte_in(wdata),
        .valid(wr && clk_en && (addr == `REG_CMD)),
        .cmd(cmd)
    );

    // Hardware pin low or soft reset both initialise
    assign init_active = !chip_init_pin_n || cmd.srst; // R9

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_state = state;
        next_state.rdata = 8'h00;
        // Reads: data valid in the following cycle only
        if (rd) begin
            case (addr)
                `REG_SETTINGS: next_state.rdata = {state.div, state.vol};
                `REG_STATUS: next_state.rdata = {1'b0, state.ps[0], state.allpts,
                                                 state.disp_on, state.bias, state.pwr};
                default: next_state.rdata = 8'h00; // Unmapped and write-only
            endcase
        end
        if (init_active) begin
            // Initial state; the supply goes off with it
            next_state.vol = `VOL_RESET; // R12
            next_state.div = `DIV_RESET; // R12
            next_state.pwr = `PWR_RESET; // R9 R12
            next_state.bias = lcd_bias_pkg::BIAS_SIXTH;
            next_state.disp_on = 1'b0;
            next_state.allpts = 1'b1;
            next_state.ps = lcd_bias_pkg::PS_SAVE;
        end else begin
            // Each setting takes effect at the write itself
            // Contrast level in the low five bits
            if (cmd.vol) begin
                next_state.vol = cmd.data[4:0]; // R1 R4 R13
            end
            // Divider ratio; code 111 hands the gain to outside parts
            if (cmd.div) begin
                next_state.div = cmd.data[2:0]; // R2 R3 R13
            end
            // Supply enables, one bit per block
            if (cmd.pwr) begin
                next_state.pwr = cmd.data[2:0]; // R11 R13
            end
            // Bias ratio from bit 0
            if (cmd.bias) begin
                next_state.bias = lcd_bias_pkg::bias_e'(cmd.data[0]); // R6 R13
            end
            // Display on or off
            if (cmd.disp) begin
                next_state.disp_on = cmd.data[0];
            end
            // All points forced on, or normal display
            if (cmd.allpts) begin
                next_state.allpts = cmd.data[0];
            end
            // Composite power save once both conditions hold
            // Either order is taken: cheaper than tracking order, same end state
            case (state.ps)
                lcd_bias_pkg::PS_ACTIVE: begin
                    if (!next_state.disp_on && next_state.allpts) begin
                        next_state.ps = lcd_bias_pkg::PS_SAVE; // R8
                    end
                end
                lcd_bias_pkg::PS_SAVE: begin
                    if (next_state.disp_on || !next_state.allpts) begin
                        next_state.ps = lcd_bias_pkg::PS_ACTIVE;
                    end
                end
                default: next_state.ps = lcd_bias_pkg::PS_ACTIVE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; clock enable freezes everything
    always_ff @(posedge clk) begin
        // Reset wins over the enable, so a frozen block can still be cleared
        if (srst) begin
            state.vol <= `VOL_RESET; // R12
            state.div <= `DIV_RESET; // R12
            state.pwr <= `PWR_RESET; // R9
            state.bias <= lcd_bias_pkg::BIAS_SIXTH;
            state.disp_on <= 1'b0;
            state.allpts <= 1'b1;
            state.ps <= lcd_bias_pkg::PS_SAVE;
            state.rdata <= 8'h00;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata = state.rdata;
    // Settings to the analog section; attenuation and flag decoded from state
    assign drive.contrast_level = state.vol;
    assign drive.atten = atten_of(state.vol); // R1
    assign drive.divider_gain_select = state.div; // R2
    assign drive.ext_divider = (state.div == `DIV_EXTERNAL); // R2 R3
    assign drive.pwr_en = state.pwr;
    assign drive.bias = state.bias; // R6
    // Supply blocks are gated off in power save as well
    assign booster_on = state.pwr[`PWR_BOOST_BIT] && (state.ps != lcd_bias_pkg::PS_SAVE); // R11
    assign regulator_on = state.pwr[`PWR_REG_BIT] && (state.ps != lcd_bias_pkg::PS_SAVE); // R11
    assign follower_on = state.pwr[`PWR_FOL_BIT] && (state.ps != lcd_bias_pkg::PS_SAVE); // R11
    assign power_save = (state.ps == lcd_bias_pkg::PS_SAVE); // R8
    assign display_on = state.disp_on;
    assign all_points_on = state.allpts;
    // Direct from the pin: the short must act even with no clock
    assign discharge_en = !chip_init_pin_n; // R10

    ////////////////////////////////////////////////////////////////////////
    // Checks on the command path
    // Contrast byte lands one cycle after its write
    a_contrast_write: assert property (@(posedge clk) disable iff (srst) // R13
        (clk_en && cmd.vol && chip_init_pin_n) |=> (drive.contrast_level == $past(wdata[4:0])))
        else $error("contrast not updated");
    // Attenuation and code always sum to full scale
    a_atten_map: assert property (@(posedge clk) disable iff (srst) // R1
        (drive.atten + drive.contrast_level) == 5'h1F)
        else $error("attenuation mismatch");
    // Mid-scale byte gives the middle code and attenuation
    a_mid_scale: assert property (@(posedge clk) disable iff (srst) // R4
        (clk_en && chip_init_pin_n && wr && addr == `REG_CMD && wdata == 8'h90)
        |=> (drive.contrast_level == 5'h10 && drive.atten == 5'h0F))
        else $error("mid-scale contrast wrong");
    // Byte 27H hands the gain to outside resistors
    a_ext_divider: assert property (@(posedge clk) disable iff (srst) // R3
        (clk_en && chip_init_pin_n && wr && addr == `REG_CMD && wdata == 8'h27)
        |=> drive.ext_divider)
        else $error("external divider not selected");
    // Divider code lands one cycle after its write
    a_div_write: assert property (@(posedge clk) disable iff (srst) // R2
        (clk_en && cmd.div && chip_init_pin_n)
        |=> (drive.divider_gain_select == $past(wdata[2:0])))
        else $error("divider not updated");
    // Only the all-ones divider code means external
    a_ext_only_seven: assert property (@(posedge clk) disable iff (srst) // R2
        drive.ext_divider == (drive.divider_gain_select == `DIV_EXTERNAL))
        else $error("external flag wrong");
    // Bias choice follows bit 0 of its command
    a_bias_write: assert property (@(posedge clk) disable iff (srst) // R6
        (clk_en && cmd.bias && chip_init_pin_n) |=> (drive.bias == $past(wdata[0])))
        else $error("bias not updated");
    // Enables follow the low three bits
    a_pwr_bits: assert property (@(posedge clk) disable iff (srst) // R11
        (clk_en && cmd.pwr && chip_init_pin_n) |=> (drive.pwr_en == $past(wdata[2:0])))
        else $error("power bits not updated");
    // No command other than power set or soft reset may move the enables
    a_pwr_hold: assert property (@(posedge clk) disable iff (srst) // R11
        (clk_en && chip_init_pin_n && wr && addr == `REG_CMD && !cmd.pwr && !cmd.srst)
        |=> $stable(drive.pwr_en))
        else $error("enables moved by another command");
    // Display and all-points levels follow bit 0
    a_disp_write: assert property (@(posedge clk) disable iff (srst)
        (clk_en && cmd.disp && chip_init_pin_n) |=> (display_on == $past(wdata[0])))
        else $error("display state not updated");
    a_allpts_write: assert property (@(posedge clk) disable iff (srst)
        (clk_en && cmd.allpts && chip_init_pin_n) |=> (all_points_on == $past(wdata[0])))
        else $error("all points state not updated");
    // Discharge follows the pin with no clock delay
    a_discharge: assert property (@(posedge clk) disable iff (srst) // R10
        discharge_en == !chip_init_pin_n)
        else $error("discharge path wrong");

    ////////////////////////////////////////////////////////////////////////
    // Checks on power save and initialisation
    // Display off while all points forced on
    sequence s_off_allon;
        !display_on && all_points_on;
    endsequence
    a_power_save: assert property (@(posedge clk) disable iff (srst) // R8
        s_off_allon |-> power_save)
        else $error("power save not entered");
    // Composite entry, whichever half arrives second
    sequence s_off_while_allon;
        clk_en && chip_init_pin_n && cmd.disp && !wdata[0] && all_points_on;
    endsequence
    sequence s_allon_while_off;
        clk_en && chip_init_pin_n && cmd.allpts && wdata[0] && !display_on;
    endsequence
    a_save_after_off: assert property (@(posedge clk) disable iff (srst) // R8
        s_off_while_allon |=> power_save)
        else $error("power save missed after display off");
    a_save_after_allon: assert property (@(posedge clk) disable iff (srst) // R8
        s_allon_while_off |=> power_save)
        else $error("power save missed after all points on");
    // Display on always leaves power save
    a_save_exit: assert property (@(posedge clk) disable iff (srst) // R8
        (clk_en && chip_init_pin_n && cmd.disp && wdata[0]) |=> !power_save)
        else $error("power save not left");

    // In power save no supply block may run
    a_supply_gate: assert property (@(posedge clk) disable iff (srst) // R8
        power_save |-> !(booster_on || regulator_on || follower_on))
        else $error("supply running in power save");
    // Out of power save each block follows its enable bit
    a_supply_follow: assert property (@(posedge clk) disable iff (srst) // R11
        !power_save |-> ({booster_on, regulator_on, follower_on} == drive.pwr_en))
        else $error("supply enables wrong");
    // Any init path restores the start-up settings
    a_reset_init: assert property (@(posedge clk) disable iff (srst) // R9 R12
        (clk_en && init_active) |=> (drive.contrast_level == 5'h10 && drive.pwr_en == 3'h0
        && drive.divider_gain_select == 3'h0 && !booster_on))
        else $error("init values wrong");
    // Pin held low keeps power save and the default bias
    a_init_state: assert property (@(posedge clk) disable iff (srst) // R9 R12
        (clk_en && !chip_init_pin_n)
        |=> (power_save && !display_on && all_points_on
        && drive.bias == lcd_bias_pkg::BIAS_SIXTH))
        else $error("init pin state wrong");
    // Soft reset drops into power save as well
    a_soft_reset_save: assert property (@(posedge clk) disable iff (srst) // R9
        (clk_en && cmd.srst) |=> (power_save && !display_on && all_points_on))
        else $error("soft reset state wrong");

    ////////////////////////////////////////////////////////////////////////
    // Checks on the register port
    // Settings read returns both codes, one cycle later
    a_settings_read: assert property (@(posedge clk) disable iff (srst) // R1 R2
        (clk_en && rd && addr == `REG_SETTINGS)
        |=> (rdata == {$past(drive.divider_gain_select), $past(drive.contrast_level)}))
        else $error("settings read wrong");
    // Status read carries the save flag and the enables
    a_status_read: assert property (@(posedge clk) disable iff (srst) // R8 R11
        (clk_en && rd && addr == `REG_STATUS)
        |=> (rdata[6] == $past(power_save) && rdata[2:0] == $past(drive.pwr_en)))
        else $error("status read wrong");
    // With enable high, read data stand one cycle only, zero otherwise
    a_rdata_idle: assert property (@(posedge clk) disable iff (srst)
        (clk_en && !rd) |=> (rdata == 8'h00))
        else $error("read data not cleared");
    // Writes to other offsets never touch a setting
    a_unmapped_write: assert property (@(posedge clk) disable iff (srst) // R13
        (clk_en && chip_init_pin_n && wr && addr != `REG_CMD) |=> $stable(drive))
        else $error("unmapped write changed a setting");
    // Enable low freezes every output that comes from state
    a_hold_frozen: assert property (@(posedge clk) disable iff (srst)
        !clk_en |=> ($stable(drive) && $stable(power_save) && $stable(rdata)))
        else $error("state moved while frozen");

endmodule // lcd_bias_voltage_control

/* lcd_bias_consts.svh */
`ifndef LCD_BIAS_CONSTS_SVH
`define LCD_BIAS_CONSTS_SVH

// Command byte encodings and masks
`define CMD_DISP_OFF 8'hAE
`define CMD_DISP_ON 8'hAF
`define CMD_ALLPTS_OFF 8'hA4
`define CMD_ALLPTS_ON 8'hA5
`define CMD_BIAS_MASK 8'hFE
`define CMD_BIAS_BASE 8'hA2
`define CMD_SOFT_RESET 8'hE2
`define CMD_PWR_MASK 8'hF8
`define CMD_PWR_BASE 8'h28
`define CMD_DIV_MASK 8'hF8
`define CMD_DIV_BASE 8'h20
`define CMD_VOL_MASK 8'hE0
`define CMD_VOL_BASE 8'h80

// Field positions
`define PWR_BOOST_BIT 2
`define PWR_REG_BIT 1
`define PWR_FOL_BIT 0

// Initial values, external divider code and full-scale contrast
`define VOL_RESET 5'h10
`define DIV_RESET 3'h0
`define PWR_RESET 3'h0
`define DIV_EXTERNAL 3'h7
`define VOL_MAX 5'h1F

// Register offsets of the plain port (command write, settings and status read)
`define REG_CMD 2'h0
`define REG_SETTINGS 2'h1
`define REG_STATUS 2'h2

`endif

/* lcd_bias_pkg.sv */
package lcd_bias_pkg;

    // Bias ratio choice
    typedef enum logic {
        BIAS_SIXTH = 1'b0,
        BIAS_EIGHTH = 1'b1
    } bias_e;

    // Power-save detector state
    typedef enum logic [1:0] {
        PS_ACTIVE = 2'b00,
        PS_SAVE = 2'b01
    } ps_e;

    // Decoded command
    typedef struct packed {
        logic vol;
        logic div;
        logic pwr;
        logic bias;
        logic disp;
        logic allpts;
        logic srst;
        logic [7:0] data;
    } cmd_s;

    // Drive settings seen by the analog section
    typedef struct packed {
        logic [4:0] contrast_level;
        logic [4:0] atten;
        logic [2:0] divider_gain_select;
        logic ext_divider;
        logic [2:0] pwr_en;
        bias_e bias;
    } drive_s;

endpackage

/* lcd_cmd_decode.sv */
`timescale 1ns/100ps
`include "lcd_bias_consts.svh"

// Combinational command-byte classifier
module lcd_cmd_decode (
    input wire logic [7:0] byte_in,
    input wire logic valid,
    output lcd_bias_pkg::cmd_s cmd
);

    // Match byte against mask and base
    function automatic logic hit(input logic [7:0] b, input logic [7:0] m,
                                 input logic [7:0] base);
        hit = ((b & m) == base);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode, one class per byte at most
    always_comb begin
        cmd.data = byte_in;
        cmd.vol = valid && hit(byte_in, `CMD_VOL_MASK, `CMD_VOL_BASE); // R4
        cmd.div = valid && hit(byte_in, `CMD_DIV_MASK, `CMD_DIV_BASE); // R3
        cmd.pwr = valid && hit(byte_in, `CMD_PWR_MASK, `CMD_PWR_BASE);
        cmd.bias = valid && hit(byte_in, `CMD_BIAS_MASK, `CMD_BIAS_BASE);
        cmd.disp = valid && hit(byte_in, 8'hFE, `CMD_DISP_OFF);
        cmd.allpts = valid && hit(byte_in, 8'hFE, `CMD_ALLPTS_OFF);
        cmd.srst = valid && (byte_in == `CMD_SOFT_RESET);
    end

endmodule // lcd_cmd_decode

/* lcd_host_model.sv */
`timescale 1ns/100ps
// Host processor model: writes command bytes, reads registers back
module lcd_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [1:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    ////////////////////////////////////////////////////////////
    // Idle bus from time zero
    initial begin
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One write cycle; stale data is inverted so it never looks valid
    task automatic put(input logic [1:0] a, input logic [7:0] b);
        @(posedge clk);
        addr <= a;
        wdata <= b;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~b;
        #1;
    endtask

    // One read cycle; data stand only in the following cycle
    task automatic get(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Supply up: regulator and follower always, booster optional
    task automatic power_up(input logic boost);
        put(2'h0, {5'h05, boost, 2'h3});
    endtask

    // Shut-down order: display off, all points on, enables cleared
    task automatic power_down();
        put(2'h0, 8'hAE);
        put(2'h0, 8'hA5);
        put(2'h0, 8'h28);
    endtask
endmodule // lcd_host_model

/* lcd_bias_voltage_control_test.sv */
`timescale 1ns/100ps
// Self-checking bench for the drive-voltage command block
module lcd_bias_voltage_control_test;
    logic clk;
    logic srst;
    logic clk_en;
    logic chip_init_pin_n;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    lcd_bias_pkg::drive_s drive;
    logic booster_on;
    logic regulator_on;
    logic follower_on;
    logic power_save;
    logic display_on;
    logic all_points_on;
    logic discharge_en;
    int err_count;
    int n_tests;
    logic [7:0] rv;
    logic [19:0] rows [0:10]; // Command, contrast, divider, power bits, bias

    lcd_bias_voltage_control uut (.clk(clk), .srst(srst), .clk_en(clk_en),
        .chip_init_pin_n(chip_init_pin_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .drive(drive), .booster_on(booster_on),
        .regulator_on(regulator_on), .follower_on(follower_on),
        .power_save(power_save), .display_on(display_on),
        .all_points_on(all_points_on), .discharge_en(discharge_en));
    lcd_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    ////////////////////////////////////////////////////////////
    // Free-running clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Whole settings struct, attenuation and external flag derived here
    task automatic chk_drive(input logic [4:0] c, input logic [2:0] d,
                             input logic [2:0] p, input logic b);
        lcd_bias_pkg::drive_s e;
        e = {c, 5'h1F - c, d, d == 3'h7, p, b};
        n_tests++;
        if (drive !== e) begin
            err_count++;
            $display("wrong value at %0t: drive %h expected %h", $time, drive, e);
        end
    endtask

    // Byte or flag results
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Single place where the run ends
    task automatic stop_test();
        $display("errors %0d, checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #200000;
        err_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        srst = 1'b1;
        chip_init_pin_n = 1'b1;
        clk_en = 1'b1;
        err_count = 0;
        n_tests = 0;
        rows = '{{8'h80, 5'h00, 3'h0, 3'h7, 1'b0}, {8'h9F, 5'h1F, 3'h0, 3'h7, 1'b0},
                 {8'h90, 5'h10, 3'h0, 3'h7, 1'b0}, {8'h27, 5'h10, 3'h7, 3'h7, 1'b0},
                 {8'h23, 5'h10, 3'h3, 3'h7, 1'b0}, {8'h20, 5'h10, 3'h0, 3'h7, 1'b0},
                 {8'h2C, 5'h10, 3'h0, 3'h4, 1'b0}, {8'h2B, 5'h10, 3'h0, 3'h3, 1'b0},
                 {8'h2F, 5'h10, 3'h0, 3'h7, 1'b0}, {8'hA3, 5'h10, 3'h0, 3'h7, 1'b1},
                 {8'hA2, 5'h10, 3'h0, 3'h7, 1'b0}};
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk_drive(5'h10, 3'h0, 3'h0, 1'b0);
        chk_val({7'h00, power_save}, 8'h01);
        host.get(2'h2, rv);
        chk_val(rv, 8'h60);
        host.get(2'h1, rv);
        chk_val(rv, 8'h10);
        chk_val({6'h00, display_on, all_points_on}, 8'h01);
        // Display off while all points already on keeps power save
        host.put(2'h0, 8'hAE);
        chk_val({7'h00, power_save}, 8'h01);
        // Regulator and follower up before any contrast work
        host.power_up(1'b1);
        for (int i = 0; i < 11; i++) begin
            host.put(2'h0, rows[i][19:12]);
            chk_drive(rows[i][11:7], rows[i][6:4], rows[i][3:1], rows[i][0]);
        end
        // Still in power save, so supplies stay gated
        chk_val({5'h00, booster_on, regulator_on, follower_on}, 8'h00);
        host.put(2'h0, 8'hA4);
        chk_val({5'h00, booster_on, regulator_on, follower_on}, 8'h07);
        host.put(2'h0, 8'hAF);
        chk_val({5'h00, power_save, display_on, all_points_on}, 8'h02);
        host.get(2'h2, rv);
        chk_val(rv, 8'h17);
        chk_val(rdata, rv);
        @(posedge clk);
        #1;
        chk_val(rdata, 8'h00);
        host.power_down();
        chk_val({7'h00, power_save}, 8'h01);
        chk_val({6'h00, display_on, all_points_on}, 8'h01);
        chk_drive(5'h10, 3'h0, 3'h0, 1'b0);
        // Unmapped write and read are refused
        host.put(2'h1, 8'h9F);
        chk_drive(5'h10, 3'h0, 3'h0, 1'b0);
        host.get(2'h3, rv);
        chk_val(rv, 8'h00);
        // Soft reset restores the initial settings
        host.power_up(1'b1);
        host.put(2'h0, 8'h85);
        host.put(2'h0, 8'hE2);
        chk_drive(5'h10, 3'h0, 3'h0, 1'b0);
        // Bench reset in mid-run, one cycle long
        host.put(2'h0, 8'h85);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        chk_drive(5'h10, 3'h0, 3'h0, 1'b0);
        chk_val({5'h00, power_save, display_on, all_points_on}, 8'h05);
        // Enable low: a write and a read are both frozen out
        @(posedge clk);
        clk_en <= 1'b0;
        host.put(2'h0, 8'h9F);
        chk_drive(5'h10, 3'h0, 3'h0, 1'b0);
        host.get(2'h1, rv);
        chk_val(rv, 8'h00);
        @(posedge clk);
        clk_en <= 1'b1;
        // Hardware init pin: discharge at once, settings at next edge
        host.put(2'h0, 8'h85);
        @(posedge clk);
        chip_init_pin_n <= 1'b0;
        #1;
        chk_val({7'h00, discharge_en}, 8'h01);
        host.put(2'h0, 8'h27);
        chk_drive(5'h10, 3'h0, 3'h0, 1'b0);
        @(posedge clk);
        chip_init_pin_n <= 1'b1;
        #1;
        chk_val({7'h00, discharge_en}, 8'h00);
        stop_test();
    end
endmodule // lcd_bias_voltage_control_test
